/* File: testbench/nop_nvm_model.sv */
// nonvolatile store model feeding option, protection and key images
`timescale 1ns/100ps
module nop_nvm_model (
    // selects the second stored option image
    input wire logic alt_i,
    // stored images
    output logic [7:0] opt_o,
    output logic [7:0] prot_o,
    output logic [63:0] key_o
);
    assign opt_o = alt_i ? 8'h01 : 8'hE1;
    assign prot_o = 8'hBE;
    // key value is arbitrary
    assign key_o = 64'h0123_4567_89AB_CDEF;
endmodule

/* File: testbench/nvm_option_and_protection_regs_test.sv */
// self-checking bench for the nvm option and protection registers
`timescale 1ns/100ps
module nvm_option_and_protection_regs_test;
    import nop_pkg::*;
    logic clk_sys_i = 0, arst_n_i = 0, alt = 0, cyc = 0, we = 0, dbg = 0, kwr = 0, kdbg = 0;
    logic cl = 0, bok = 0, mreq = 1, msec = 0;
    logic [3:0] adr = 0;
    logic [31:0] dat = 0, rdat, r;
    logic [15:0] kadr = 0, cadr = 0;
    logic [7:0] kdat = 0, code = 0, nv_opt, nv_prot, v, m_opt, m_prot, m_cfg;
    logic [63:0] nv_key;
    logic ack, go, eb, kst, grant, sec, rd, lay, ps, flag, m_flag, m_sec;
    logic [7:0] codes [6] = '{8'h05, 8'h20, 8'h25, 8'h40, 8'h41, 8'h47};
    int fail_count = 0, compares = 0;
    always #5 clk_sys_i = ~clk_sys_i;
    nop_nvm_model nvm (.alt_i(alt), .opt_o(nv_opt), .prot_o(nv_prot), .key_o(nv_key));
    nop_top dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .stored_option_byte_i(nv_opt),
        .stored_protection_byte_i(nv_prot), .stored_backdoor_key_i(nv_key), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .debug_command_mode_i(dbg), .key_wr_i(kwr), .key_from_debug_i(kdbg), .key_adr_i(kadr),
        .key_dat_i(kdat), .cmd_launch_i(cl), .cmd_code_i(code), .cmd_adr_i(cadr), .blank_ok_i(bok),
        .mem_req_i(mreq), .mem_src_secure_i(msec), .cmd_go_o(go), .cmd_erase_both_o(eb),
        .key_cmd_start_o(kst), .mem_grant_o(grant), .secure_o(sec), .redirect_disable_o(rd),
        .sector_layout_o(lay), .page_select_o(ps), .protection_violation_flag_o(flag));
    task report_and_stop(input bit to);
        if (to) fail_count++;
        if (fail_count == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task rst(input logic a);
        alt <= a;
        arst_n_i <= 0;
        repeat (20) @(posedge clk_sys_i);
        arst_n_i <= 1;
        repeat (2) @(posedge clk_sys_i);
        m_opt = nv_opt;
        m_prot = nv_prot;
        m_cfg = 0;
        m_flag = 0;
        m_sec = m_opt[1:0] != NOP_SEC_UNSECURE;
    endtask
    // one classic cycle, held until ack is seen at an edge
    task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        cyc <= 1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        r = rdat;
        cyc <= 0;
        if (ack !== 1'b1) report_and_stop(1);
    endtask
    task sec_chk;
        @(posedge clk_sys_i);
        chk(sec, m_sec);
        chk(grant, mreq & (msec | !m_sec));
        mreq <= 1'($urandom);
        msec <= 1'($urandom);
    endtask
    function automatic bit hit(logic [15:0] a);
        int e, f, b;
        e = m_prot[7:6];
        f = m_prot[5:0];
        b = e == 2 ? 'h17F0 : e == 1 ? 'h17E0 : 'h17C0;
        hit = (e != 3 && a >= b && a <= 'h17FF) || (f != 63 && a >= (f <= 'h18 ? 0 : 'h10000 - (63 - f) * 'h600));
    endfunction
    task key(input int i, input logic d);
        @(posedge clk_sys_i);
        kwr <= 1;
        kdbg <= d;
        kadr <= 16'hFFB0 + 16'(i);
        kdat <= nv_key[8*i +: 8];
        @(posedge clk_sys_i);
        kwr <= 0;
        @(posedge clk_sys_i);
        chk(kst, !m_cfg[5]);
    endtask
    task keys(input logic d);
        for (int i = 0; i < 8; i++) key(i, d);
        repeat (2) @(posedge clk_sys_i);
        if (!d && m_opt[7]) m_sec = 0;
    endtask
    task cmd(input logic [7:0] c, input logic [15:0] a, input logic ok);
        logic blk;
        blk = (c == NOP_CMD_MASS) ? (m_prot != 8'hFF) : (c != NOP_CMD_BLANK && hit(a));
        @(posedge clk_sys_i);
        cl <= 1;
        code <= c;
        cadr <= a;
        bok <= ok;
        @(posedge clk_sys_i);
        cl <= 0;
        @(posedge clk_sys_i);
        chk(go, !blk);
        chk(eb, !blk && c == NOP_CMD_SECTOR && !m_opt[5]);
        m_flag |= blk;
        chk(flag, m_flag);
        if (c == NOP_CMD_BLANK && ok) m_sec = 0;
    endtask
    initial begin
        void'($urandom(81));
        rst(0);
        wb(1, NOP_OFS_OPTIONS, 32'h0000_00FF);
        wb(0, NOP_OFS_OPTIONS, 0);
        chk(r, m_opt);
        chk({rd, lay}, m_opt[6:5]);
        wb(0, NOP_OFS_PROTECT, 0);
        chk(r, nv_prot);
        sec_chk();
        wb(1, NOP_OFS_CONFIG, 32'h0000_00FF);
        wb(0, NOP_OFS_CONFIG, 0);
        chk(r, 32'h0000_0060);
        chk(ps, 1);
        m_cfg = 8'h20;
        wb(1, NOP_OFS_CONFIG, m_cfg);
        chk(ps, 0);
        keys(1);
        sec_chk();
        keys(0);
        sec_chk();
        m_cfg = 0;
        wb(1, NOP_OFS_CONFIG, 0);
        key(0, 0);
        // random writes may only enlarge protection
        for (int i = 0; i < 24; i++) begin
            v = 8'($urandom);
            wb(1, NOP_OFS_PROTECT, v);
            if (v[7:6] <= m_prot[7:6] && v[5:0] <= m_prot[5:0]) m_prot = v;
            wb(0, NOP_OFS_PROTECT, 0);
            chk(r, m_prot);
            cmd(codes[i % 6], i[0] ? 16'($urandom) : 16'h1780 + 16'($urandom % 128), 0);
        end
        cmd(NOP_CMD_SECTOR, 16'hFFFF, 0);
        wb(0, NOP_OFS_STATUS, 0);
        chk(r[5], m_flag);
        wb(1, NOP_OFS_STATUS, 32'h0000_0020);
        m_flag = 0;
        wb(0, NOP_OFS_STATUS, 0);
        chk(r[5], 0);
        dbg <= 1;
        wb(1, NOP_OFS_PROTECT, 32'h0000_00FF);
        dbg <= 0;
        m_prot = 8'hFF;
        wb(0, NOP_OFS_PROTECT, 0);
        chk(r, m_prot);
        cmd(NOP_CMD_MASS, 0, 0);
        rst(1);
        wb(0, NOP_OFS_OPTIONS, 0);
        chk(r, m_opt);
        chk({rd, lay}, m_opt[6:5]);
        m_cfg = 8'h20;
        wb(1, NOP_OFS_CONFIG, m_cfg);
        keys(0);
        sec_chk();
        cmd(NOP_CMD_SECTOR, 16'h1000, 0);
        cmd(NOP_CMD_BLANK, 0, 0);
        sec_chk();
        cmd(NOP_CMD_BLANK, 0, 1);
        sec_chk();
        report_and_stop(0);
    end
endmodule

/* File: verilog/nop_pkg.sv */
// package: register map, field positions and constants for the nvm option and protection block
package nop_pkg;
    // word byte offsets on the wishbone slave
    localparam logic [3:0] NOP_OFS_OPTIONS = 4'h0;
    localparam logic [3:0] NOP_OFS_CONFIG = 4'h4;
    localparam logic [3:0] NOP_OFS_PROTECT = 4'h8;
    localparam logic [3:0] NOP_OFS_STATUS = 4'hC;
    // options register fields
    localparam int NOP_KEY_ENABLE_BIT_BIT = 7;
    localparam int NOP_NORED_BIT = 6;
    localparam int NOP_LAYOUT_BIT = 5;
    localparam logic [1:0] NOP_SEC_UNSECURE = 2'h2;
    // configuration register fields
    localparam int NOP_PAGE_BIT = 6;
    localparam int NOP_KEYWR_BIT = 5;
    localparam logic [7:0] NOP_CFG_MASK = 8'h60;
    localparam logic [7:0] NOP_CFG_RESET = 8'h00;
    // status register fields
    localparam int NOP_VIOL_BIT = 5;
    // protection decode
    localparam logic [1:0] NOP_EPS_NONE = 2'h3;
    localparam logic [15:0] NOP_EE_TOP = 16'h17FF;
    localparam logic [15:0] NOP_EE_BASE2 = 16'h17F0;
    localparam logic [15:0] NOP_EE_BASE1 = 16'h17E0;
    localparam logic [15:0] NOP_EE_BASE0 = 16'h17C0;
    localparam logic [5:0] NOP_FPS_NONE = 6'h3F;
    localparam logic [5:0] NOP_FPS_ALL = 6'h18;
    localparam logic [15:0] NOP_FL_STEP = 16'h0600;
    // key window
    localparam logic [15:0] NOP_KEY_BASE = 16'hFFB0;
    localparam int NOP_KEY_BYTES = 8;
    // command codes
    localparam logic [7:0] NOP_CMD_BLANK = 8'h05;
    localparam logic [7:0] NOP_CMD_MASS = 8'h41;
    localparam logic [7:0] NOP_CMD_SECTOR = 8'h40;
endpackage

/* File: verilog/nop_top.sv */
// nvm option, configuration and protection registers with security and key logic
//
// Implementation choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/100ps
// Behaviour
// (R1) options register loads from stored option byte each reset only
// (R2) backdoor unlock refused while key enable bit is zero
// (R3) key comparison writes accepted from firmware only, never debug
// (R4) eight matching key bytes in order unsecure until next reset
// (R5) options bit 6 high disables vector redirection
// (R6) options bit 5 selects split or single page eeprom sectors
// (R7) security field pattern 1:0 alone means unsecured
// (R8) while secure, unsecured sources blocked from memory contents
// (R9) security field becomes 1:0 after key match or full blank check
// (R10) config bit 6 selects eeprom foreground page
// (R11) config bit 5 routes key range writes to key compare or command
// (R12) protection register loads from stored protection byte at reset
// (R13) protection readable always; writes only enlarge protected region
// (R14) program or erase in protected area blocked, sets violation flag
// (R15) mass erase rejected when any sector protected
// (R16) debug commands may change protection bits freely
// (R17) bits 7:6 select eeprom protected range
// (R18) bits 5:0 select flash protected range in 1.5K steps
// (R19) violation flag sticky until software writes one
// (R20) split mode sector erase clears both four byte halves
// (R21) target checked against eeprom and flash ranges before launch
module nop_top
    import nop_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // nonvolatile values presented during reset
    input wire logic [7:0] stored_option_byte_i,
    input wire logic [7:0] stored_protection_byte_i,
    input wire logic [63:0] stored_backdoor_key_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // debug command mode marks a debug source for protection writes
    input wire logic debug_command_mode_i,
    // cpu write into the key range
    input wire logic key_wr_i,
    input wire logic key_from_debug_i,
    input wire logic [15:0] key_adr_i,
    input wire logic [7:0] key_dat_i,
    // command launch from sequencer
    input wire logic cmd_launch_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic [15:0] cmd_adr_i,
    input wire logic blank_ok_i,
    // memory access request from a source
    input wire logic mem_req_i,
    input wire logic mem_src_secure_i,
    // outputs
    output logic cmd_go_o,
    output logic cmd_erase_both_o,
    output logic key_cmd_start_o,
    output logic mem_grant_o,
    output logic secure_o,
    output logic redirect_disable_o,
    output logic sector_layout_o,
    output logic page_select_o,
    output logic protection_violation_flag_o
);
    logic [7:0] opt_q;
    logic [7:0] cfg_q;
    logic [7:0] prot_q;
    logic viol_q;
    logic unlock_q;
    logic [3:0] key_idx_q;
    logic key_ok_q;
    logic ack_q;
    logic [31:0] rdat_q;
    logic loaded_q;
    logic cmd_go_q;
    logic erase_both_q;
    logic key_start_q;

    // decode
    wire bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
    wire bus_wr = bus_req & wb_we_i & wb_sel_i[0];
    wire sel_cfg = (wb_adr_i == NOP_OFS_CONFIG);
    wire sel_prot = (wb_adr_i == NOP_OFS_PROTECT);
    wire sel_stat = (wb_adr_i == NOP_OFS_STATUS);
    wire sel_opt = (wb_adr_i == NOP_OFS_OPTIONS);
    wire [7:0] wr_byte = wb_dat_i[7:0];

    // (R7) security decode
    wire sec_unsecure = (opt_q[1:0] == NOP_SEC_UNSECURE);

    // (R13) enlarge-only check; smaller code protects more
    wire prot_grow = (wr_byte[7:6] <= prot_q[7:6]) && (wr_byte[5:0] <= prot_q[5:0]);
    // (R16) debug writes bypass the enlarge-only check
    wire prot_wr = bus_wr & sel_prot & (debug_command_mode_i | prot_grow);

    // (R17) eeprom range decode
    wire [15:0] ee_base = (prot_q[7:6] == 2'h2) ? NOP_EE_BASE2 :
                          (prot_q[7:6] == 2'h1) ? NOP_EE_BASE1 : NOP_EE_BASE0;
    wire ee_on = (prot_q[7:6] != NOP_EPS_NONE);
    wire ee_hit = ee_on && (cmd_adr_i >= ee_base) && (cmd_adr_i <= NOP_EE_TOP);
    // (R18) flash range decode
    wire [5:0] fl_steps = NOP_FPS_NONE - prot_q[5:0];
    wire [15:0] fl_size = 16'(fl_steps * NOP_FL_STEP);
    wire [15:0] fl_base = 16'(17'h1_0000 - {1'b0, fl_size});
    wire fl_on = (prot_q[5:0] != NOP_FPS_NONE);
    wire fl_all = (prot_q[5:0] <= NOP_FPS_ALL);
    wire fl_hit = fl_on && (fl_all || (cmd_adr_i >= fl_base));
    // (R21) address compared against both ranges
    wire is_mass = (cmd_code_i == NOP_CMD_MASS);
    wire is_blank = (cmd_code_i == NOP_CMD_BLANK);
    wire prot_block = is_blank ? 1'b0 : (is_mass ? (ee_on | fl_on) : (ee_hit | fl_hit));
    wire violation = cmd_launch_i & prot_block;

    // (R3) debug sourced key writes never count
    wire key_path = key_wr_i & cfg_q[NOP_KEYWR_BIT] & (key_adr_i[15:3] == NOP_KEY_BASE[15:3]);
    wire key_fw = key_path & ~key_from_debug_i;
    wire key_exp = (key_adr_i[2:0] == key_idx_q[2:0]);
    wire key_last = (key_idx_q == 4'(NOP_KEY_BYTES - 1));
    // (R4) one compare lane per key byte
    logic [NOP_KEY_BYTES-1:0] key_lane_hit;
    for (genvar g = 0; g < NOP_KEY_BYTES; g++) begin : g_key_lane
        assign key_lane_hit[g] = (key_idx_q[2:0] == 3'(g)) && (key_dat_i == stored_backdoor_key_i[8 * g +: 8]);
    end
    wire key_byte_ok = key_exp && (|key_lane_hit);

    // (R1) (R12) capture nonvolatile bytes on first edge after reset release
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            loaded_q <= 1'b0;
            opt_q <= 8'h00;
            prot_q <= 8'hFF;
        end else if (!loaded_q) begin
            loaded_q <= 1'b1;
            opt_q <= stored_option_byte_i;
            prot_q <= stored_protection_byte_i;
        end else begin
            // (R9) unsecure after key match or blank check
            if (unlock_q || (cmd_launch_i && is_blank && blank_ok_i)) begin
                opt_q <= {opt_q[7:2], NOP_SEC_UNSECURE};
            end
            if (prot_wr) begin
                prot_q <= wr_byte;
            end
        end
    end

    // (R10) (R11) configuration register
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cfg_q <= NOP_CFG_RESET;
        end else if (bus_wr && sel_cfg) begin
            cfg_q <= wr_byte & NOP_CFG_MASK;
        end
    end

    // (R14) (R19) sticky violation; set wins over clear
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            viol_q <= 1'b0;
        end else if (violation) begin
            viol_q <= 1'b1;
        end else if (bus_wr && sel_stat && wr_byte[NOP_VIOL_BIT]) begin
            viol_q <= 1'b0;
        end
    end

    // (R2) (R4) sequential key compare
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            key_idx_q <= 4'h0;
            key_ok_q <= 1'b1;
            unlock_q <= 1'b0;
        end else begin
            unlock_q <= 1'b0;
            if (key_fw) begin
                if (key_last) begin
                    key_idx_q <= 4'h0;
                    key_ok_q <= 1'b1;
                    unlock_q <= key_ok_q & key_byte_ok & opt_q[NOP_KEY_ENABLE_BIT_BIT] & loaded_q;
                end else begin
                    key_idx_q <= key_idx_q + 4'h1;
                    key_ok_q <= key_ok_q & key_byte_ok;
                end
            end
        end
    end

    // command launch outputs
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cmd_go_q <= 1'b0;
            erase_both_q <= 1'b0;
            key_start_q <= 1'b0;
        end else begin
            // (R14) (R15) blocked commands never go
            cmd_go_q <= cmd_launch_i & ~prot_block;
            // (R20) split mode erases both halves
            erase_both_q <= cmd_launch_i & ~prot_block & (cmd_code_i == NOP_CMD_SECTOR)
                            & ~opt_q[NOP_LAYOUT_BIT];
            // (R11) key range write treated as command start
            key_start_q <= key_wr_i & ~cfg_q[NOP_KEYWR_BIT] & (key_adr_i[15:3] == NOP_KEY_BASE[15:3]);
        end
    end

    // bus read data and ack; registered, one wait state, unmapped reads zero
    wire [7:0] rd_byte = sel_opt ? opt_q : sel_cfg ? cfg_q : sel_prot ? prot_q :
                         sel_stat ? {2'b00, viol_q, 5'b00000} : 8'h00;
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q <= bus_req;
            rdat_q <= bus_req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign cmd_go_o = cmd_go_q;
    assign cmd_erase_both_o = erase_both_q;
    assign key_cmd_start_o = key_start_q;
    assign secure_o = ~sec_unsecure;
    // (R8) secure blocks unsecured sources
    assign mem_grant_o = mem_req_i & (sec_unsecure | mem_src_secure_i);
    // (R5) (R6) option bits driven out
    assign redirect_disable_o = opt_q[NOP_NORED_BIT];
    assign sector_layout_o = opt_q[NOP_LAYOUT_BIT];
    assign page_select_o = cfg_q[NOP_PAGE_BIT];
    assign protection_violation_flag_o = viol_q;

    property p_viol_set;
        @(posedge clk_sys_i) disable iff (!arst_n_i) violation |=> viol_q;
    endproperty
    a_viol_set: assert property (p_viol_set) else $error("violation flag not set"); // (R14)

    property p_viol_hold;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
            viol_q && !(bus_wr && sel_stat && wr_byte[NOP_VIOL_BIT]) |=> viol_q;
    endproperty
    a_viol_hold: assert property (p_viol_hold) else $error("violation flag dropped"); // (R19)

    property p_no_go_blocked;
        @(posedge clk_sys_i) disable iff (!arst_n_i) violation |=> !cmd_go_o;
    endproperty
    a_no_go_blocked: assert property (p_no_go_blocked) else $error("protected command launched"); // (R14)

    property p_mass_reject;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
            cmd_launch_i && is_mass && (prot_q != 8'hFF) |=> !cmd_go_o;
    endproperty
    a_mass_reject: assert property (p_mass_reject) else $error("mass erase with protection"); // (R15)

    property p_grow_only;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
            loaded_q && bus_wr && sel_prot && !debug_command_mode_i |=>
            (prot_q[7:6] <= $past(prot_q[7:6])) && (prot_q[5:0] <= $past(prot_q[5:0]));
    endproperty
    a_grow_only: assert property (p_grow_only) else $error("protection shrank"); // (R13)

    property p_grant;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
            mem_req_i && secure_o && !mem_src_secure_i |-> !mem_grant_o;
    endproperty
    a_grant: assert property (p_grant) else $error("secure access granted"); // (R8)

    property p_unlock_key_enable_bit;
        @(posedge clk_sys_i) disable iff (!arst_n_i) unlock_q |-> $past(opt_q[NOP_KEY_ENABLE_BIT_BIT]);
    endproperty
    a_unlock_key_enable_bit: assert property (p_unlock_key_enable_bit) else $error("unlock without key enable"); // (R2)

    property p_unlock_sec;
        @(posedge clk_sys_i) disable iff (!arst_n_i) unlock_q |=> !secure_o;
    endproperty
    a_unlock_sec: assert property (p_unlock_sec) else $error("key match did not unsecure"); // (R9)

    property p_ack;
        @(posedge clk_sys_i) disable iff (!arst_n_i) bus_req |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("bus ack timing wrong"); // (R13)

    property p_load;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
            $rose(loaded_q) |-> (opt_q == $past(stored_option_byte_i)) &&
            (prot_q == $past(stored_protection_byte_i));
    endproperty
    a_load: assert property (p_load) else $error("stored bytes not loaded"); // (R1) (R12)

    property p_opt_stable;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
            loaded_q && !unlock_q && !(cmd_launch_i && is_blank && blank_ok_i) |=> $stable(opt_q);
    endproperty
    a_opt_stable: assert property (p_opt_stable) else $error("options changed without reset"); // (R1)

    property p_prot_stable;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
            loaded_q && !prot_wr |=> $stable(prot_q);
    endproperty
    a_prot_stable: assert property (p_prot_stable) else $error("protection changed without write"); // (R13)

    property p_prot_read;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
            bus_req && !wb_we_i && sel_prot |=> wb_dat_o == {24'h00_0000, $past(prot_q)};
    endproperty
    a_prot_read: assert property (p_prot_read) else $error("protection read wrong"); // (R13)

    property p_dbg_prot;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
            loaded_q && bus_wr && sel_prot && debug_command_mode_i |=> prot_q == $past(wr_byte);
    endproperty
    a_dbg_prot: assert property (p_dbg_prot) else $error("debug protection write lost"); // (R16)

    property p_cfg_write;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
            bus_wr && sel_cfg |=> cfg_q == ($past(wb_dat_i[7:0]) & NOP_CFG_MASK);
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("config write wrong"); // (R10) (R11)

    property p_key_debug;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
            key_wr_i && key_from_debug_i |=> $stable(key_idx_q) && !unlock_q;
    endproperty
    a_key_debug: assert property (p_key_debug) else $error("debug key write counted"); // (R3)

    property p_key_bad;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
            key_fw && key_last && !key_byte_ok |=> !unlock_q;
    endproperty
    a_key_bad: assert property (p_key_bad) else $error("unlock on bad last byte"); // (R4)

    property p_key_wrap;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
            key_fw && key_last |=> key_idx_q == 4'h0;
    endproperty
    a_key_wrap: assert property (p_key_wrap) else $error("key index did not wrap"); // (R4)

    property p_sec_sticky;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
            loaded_q && !secure_o |=> !secure_o;
    endproperty
    a_sec_sticky: assert property (p_sec_sticky) else $error("security returned before reset"); // (R4)

    property p_blank_unsec;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
            loaded_q && cmd_launch_i && is_blank && blank_ok_i |=> !secure_o;
    endproperty
    a_blank_unsec: assert property (p_blank_unsec) else $error("blank check did not unsecure"); // (R9)

    property p_go;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
            cmd_launch_i && !prot_block |=> cmd_go_o;
    endproperty
    a_go: assert property (p_go) else $error("free command not launched"); // (R14)

    property p_erase_both;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
            cmd_launch_i && !prot_block && (cmd_code_i == NOP_CMD_SECTOR) && !sector_layout_o |=> cmd_erase_both_o;
    endproperty
    a_erase_both: assert property (p_erase_both) else $error("split erase missed half"); // (R20)

    property p_key_start;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
            key_wr_i && !cfg_q[NOP_KEYWR_BIT] && (key_adr_i[15:3] == NOP_KEY_BASE[15:3]) |=> key_cmd_start_o;
    endproperty
    a_key_start: assert property (p_key_start) else $error("key range write not a command"); // (R11)

    property p_viol_clear;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
            !violation && bus_wr && sel_stat && wr_byte[NOP_VIOL_BIT] |=> !viol_q;
    endproperty
    a_viol_clear: assert property (p_viol_clear) else $error("violation flag not cleared"); // (R19)

    c_viol: cover property (@(posedge clk_sys_i) disable iff (!arst_n_i) violation);
    c_unlock: cover property (@(posedge clk_sys_i) disable iff (!arst_n_i) unlock_q);
    c_prot_wr: cover property (@(posedge clk_sys_i) disable iff (!arst_n_i) prot_wr);
    c_go: cover property (@(posedge clk_sys_i) disable iff (!arst_n_i) cmd_go_o);
    c_blank: cover property (@(posedge clk_sys_i) disable iff (!arst_n_i) cmd_launch_i && is_blank && blank_ok_i);
endmodule
